/* File: verilog/osc_clock_switch.sv */
// twin oscillator clock switch: control bits, sleep gating, clock enables
`timescale 1ns/1ns
`default_nettype none
module osc_clock_switch
   import osc_ctrl_pkg::*;
#(
   parameter int SETTLE_COUNT = SETTLE_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire io_req_type io_req,
   output logic [3:0] io_rdata,
   input wire logic sleep_instruction,
   input wire logic wake_event,
   output logic slow_osc_run,
   output logic fast_osc_run,
   output logic fast_osc_stable,
   output logic cpu_clock_select_out,
   output logic cpu_clk_en,
   output logic timer_tick
);
   logic fast_osc_enable_r;
   logic cpu_clock_select_r;
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W:0] acc_sum;
   logic slow_tick_r;
   logic ctrl_wr;
   logic ctrl_rd;
   power_state_type state_r;
   power_state_type state_nxt;

   // one step of the fractional divider
   function automatic logic [ACC_W:0] acc_step(input logic [ACC_W-1:0] a);
      logic [ACC_W-1:0] sum;
      sum = a + ACC_STEP;
      if (sum >= ACC_MODULUS)
         acc_step = {1'b1, sum - ACC_MODULUS};
      else
         acc_step = {1'b0, sum};
   endfunction

   // next accumulator value with its carry in the top bit
   assign acc_sum = acc_step(acc_r);

   // address decode of the control word
   assign ctrl_wr = io_req.wr && (io_req.addr == OSC_CTRL_ADDR);
   assign ctrl_rd = io_req.rd && (io_req.addr == OSC_CTRL_ADDR);

   // control bits, cleared by initial reset
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         fast_osc_enable_r <= FAST_EN_RESET;
         cpu_clock_select_r <= CLK_SEL_RESET;
      end
      else if (ctrl_wr)
      begin
         fast_osc_enable_r <= io_req.wdata[FAST_EN_BIT];
         cpu_clock_select_r <= io_req.wdata[CLK_SEL_BIT];
      end
   end

   // read back; low two bits are unused and read 0
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         io_rdata <= 4'h0;
      else if (ctrl_rd)
      begin
         io_rdata <= 4'h0;
         io_rdata[FAST_EN_BIT] <= fast_osc_enable_r;
         io_rdata[CLK_SEL_BIT] <= cpu_clock_select_r;
      end
      else
         io_rdata <= 4'h0;
   end

   // power state: sleep wins over a simultaneous wake
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:
            if (sleep_instruction)
               state_nxt = ST_SLEEP;
         ST_SLEEP:
            if (wake_event && !sleep_instruction)
               state_nxt = ST_RUN;
         default:
            state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         state_r <= ST_RUN;
      else
         state_r <= state_nxt;
   end

   // oscillator run outputs; both stop in sleep
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         slow_osc_run <= 1'b1;
         fast_osc_run <= 1'b0;
      end
      else
      begin
         slow_osc_run <= (state_nxt == ST_RUN);
         // disabling takes effect at once, no wait needed
         fast_osc_run <= (state_nxt == ST_RUN) &&
            (ctrl_wr ? io_req.wdata[FAST_EN_BIT] : fast_osc_enable_r);
      end
   end

   // slow clock model: 32.768 kHz enable from the 10 MHz clock
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         acc_r <= '0;
         slow_tick_r <= 1'b0;
      end
      else if (slow_osc_run)
      begin
         acc_r <= acc_sum[ACC_W-1:0];
         slow_tick_r <= acc_sum[ACC_W];
      end
      else
         slow_tick_r <= 1'b0;
   end

   settle_timer #(
      .CYCLES(SETTLE_COUNT)
   ) u_settle (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .run(fast_osc_run),
      .stable(fast_osc_stable)
   );

   // cpu clock source; an unsettled fast clock just stalls the cpu,
   // software is expected to have waited before selecting it
   assign cpu_clock_select_out = cpu_clock_select_r;
   assign cpu_clk_en = (state_r == ST_RUN) && (cpu_clock_select_r ?
      (fast_osc_run && fast_osc_stable) : slow_tick_r);
   // timers always run from the slow clock, whatever the cpu uses
   assign timer_tick = slow_tick_r;

   // gap counter between slow ticks, for checking only
   logic [9:0] gap_r;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || slow_tick_r || !slow_osc_run)
         gap_r <= 10'h000;
      else
         gap_r <= gap_r + 10'h001;
   end
   logic seen_tick_r;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !slow_osc_run)
         seen_tick_r <= 1'b0;
      else if (slow_tick_r)
         seen_tick_r <= 1'b1;
   end

   property p_reset_defaults;
      @(posedge sys_clk) sys_rst |=>
         !cpu_clock_select_out && !fast_osc_run && slow_osc_run;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("control bits not cleared by reset");

   property p_slow_after_reset;
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(sys_rst) && !ctrl_wr |-> !cpu_clock_select_out &&
         slow_osc_run && (cpu_clk_en == slow_tick_r);
   endproperty
   a_slow_after_reset: assert property (p_slow_after_reset)
      else $error("cpu not on slow clock after reset");

   property p_sleep_stops;
      @(posedge sys_clk) disable iff (sys_rst)
      sleep_instruction |=> !slow_osc_run && !fast_osc_run && !cpu_clk_en;
   endproperty
   a_sleep_stops: assert property (p_sleep_stops)
      else $error("oscillators still run in sleep");

   property p_fast_off_on_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      ctrl_wr && !io_req.wdata[FAST_EN_BIT] |=> !fast_osc_run ##1
         !fast_osc_stable;
   endproperty
   a_fast_off_on_clear: assert property (p_fast_off_on_clear)
      else $error("fast oscillator not stopped on clear");

   property p_fast_on;
      @(posedge sys_clk) disable iff (sys_rst)
      ctrl_wr && io_req.wdata[FAST_EN_BIT] && state_r == ST_RUN &&
         !sleep_instruction |=> fast_osc_run;
   endproperty
   a_fast_on: assert property (p_fast_on)
      else $error("fast oscillator not started");

   property p_select;
      @(posedge sys_clk) disable iff (sys_rst)
      state_r == ST_RUN && !cpu_clock_select_out |-> cpu_clk_en == slow_tick_r;
   endproperty
   a_select: assert property (p_select)
      else $error("cpu clock not following select");

   property p_timer_slow;
      @(posedge sys_clk) disable iff (sys_rst)
      cpu_clock_select_out && state_r == ST_RUN |->
         slow_osc_run && timer_tick == slow_tick_r;
   endproperty
   a_timer_slow: assert property (p_timer_slow)
      else $error("timer lost slow clock while fast selected");

   property p_slow_rate;
      @(posedge sys_clk) disable iff (sys_rst)
      slow_tick_r && seen_tick_r |-> gap_r >= 10'(TICK_GAP_MIN - 1) &&
         gap_r <= 10'(TICK_GAP_MAX - 1);
   endproperty
   a_slow_rate: assert property (p_slow_rate)
      else $error("slow tick spacing wrong");

   property p_readback;
      @(posedge sys_clk) disable iff (sys_rst)
      ctrl_wr ##1 (ctrl_rd && !ctrl_wr) |=>
         io_rdata[FAST_EN_BIT] == $past(io_req.wdata[FAST_EN_BIT], 2) &&
         io_rdata[CLK_SEL_BIT] == $past(io_req.wdata[CLK_SEL_BIT], 2) &&
         io_rdata[1:0] == 2'h0;
   endproperty
   a_readback: assert property (p_readback)
      else $error("control word read back wrong");

   property p_quick_disable;
      @(posedge sys_clk) disable iff (sys_rst)
      !cpu_clock_select_out && ctrl_wr && !io_req.wdata[CLK_SEL_BIT] &&
         !io_req.wdata[FAST_EN_BIT] |=> (!fast_osc_run && state_r == ST_RUN)
         [*2];
   endproperty
   a_quick_disable: assert property (p_quick_disable)
      else $error("disable on slow clock not immediate");

   c_fast_cpu: cover property (@(posedge sys_clk) disable iff (sys_rst)
      cpu_clock_select_out && cpu_clk_en);
   c_sleep_wake: cover property (@(posedge sys_clk) disable iff (sys_rst)
      state_r == ST_SLEEP ##1 state_r == ST_RUN);
   c_fast_settle: cover property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(fast_osc_stable));
endmodule
`default_nettype wire

/* File: verilog/osc_ctrl_pkg.sv */
// constants and carrier types for the twin oscillator clock switch
// Summary of operation
// - after initial reset the cpu runs from the low speed oscillator
// - software starts/stops the fast oscillator and selects the cpu clock
// - entering sleep stops both the slow and the fast oscillator
// - slow oscillator keeps feeding the timekeeping timers while fast runs cpu
// - slow oscillator gives a nominal 32.768 kHz clock for low power work
// - fast oscillator stops on the sleep instruction or enable written 0
// - select 1 gives cpu the fast oscillator, select 0 the slow one
// - fast oscillator may be disabled while cpu runs from slow one
// - after returning to slow clock, disabling the fast oscillator is instant
// - fast oscillator enable is bit 2 of address FF00, readable
// - cpu clock select is bit 3 of address FF00, readable
`default_nettype none
package osc_ctrl_pkg;
   localparam logic [15:0] OSC_CTRL_ADDR = 16'hFF00;
   localparam int FAST_EN_BIT = 2;
   localparam int CLK_SEL_BIT = 3;
   localparam logic FAST_EN_RESET = 1'h0;
   localparam logic CLK_SEL_RESET = 1'h0;
   // system clock and slow oscillator rates, in hertz
   localparam int SYS_CLK_HZ = 10000000;
   localparam int SLOW_OSC_HZ = 32768;
   localparam int ACC_W = 24;
   localparam logic [ACC_W-1:0] ACC_MODULUS = 24'h989680;
   localparam logic [ACC_W-1:0] ACC_STEP = 24'h008000;
   // spacing of slow ticks in system clocks, both lengths occur
   localparam int TICK_GAP_MIN = 305;
   localparam int TICK_GAP_MAX = 306;
   // fast oscillator settling time, least figure, in microseconds
   localparam int SETTLE_TIME_US = 1000;
   localparam int SETTLE_CYCLES =
      (SETTLE_TIME_US * (SYS_CLK_HZ / 1000000) + 0);
   localparam int SETTLE_W = 16;

   typedef struct packed {
      logic [15:0] addr;
      logic [3:0] wdata;
      logic wr;
      logic rd;
   } io_req_type;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_SLEEP = 2'b10
   } power_state_type;
endpackage
`default_nettype wire

/* File: verilog/settle_timer.sv */
// settling timer: reports the fast oscillator stable after a fixed count
`timescale 1ns/1ns
`default_nettype none
module settle_timer
   import osc_ctrl_pkg::*;
#(
   parameter int CYCLES = SETTLE_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic run,
   output logic stable
);
   logic [SETTLE_W-1:0] count_r;

   // restarts whenever the oscillator is stopped, so a wake from sleep
   // waits the full settling time again
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !run)
      begin
         count_r <= '0;
         stable <= 1'b0;
      end
      else if (count_r == SETTLE_W'(CYCLES - 1))
         stable <= 1'b1;
      else
         count_r <= count_r + SETTLE_W'(1);
   end
endmodule
`default_nettype wire

/* File: verif/osc_clock_switch_tb_top.sv */
// self-checking bench for the twin oscillator clock switch
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; \
if ((g) !== (e)) begin num_errors++; \
$display("unexpected %s exp %h got %h", nm, e, g); end end
module osc_clock_switch_tb_top
   import osc_ctrl_pkg::*;
;
   localparam int SETTLE = 8;
   logic sys_clk;
   logic sys_rst;
   io_req_type io_req;
   logic sleep_instruction;
   logic wake_event;
   logic [3:0] io_rdata;
   logic slow_osc_run;
   logic fast_osc_run;
   logic fast_osc_stable;
   logic cpu_clock_select_out;
   logic cpu_clk_en;
   logic timer_tick;
   int num_errors;
   int n_compared;

   // short settle count keeps the run brief
   osc_clock_switch #(.SETTLE_COUNT(SETTLE)) i_osc_clock_switch (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .io_req(io_req),
      .io_rdata(io_rdata),
      .sleep_instruction(sleep_instruction),
      .wake_event(wake_event),
      .slow_osc_run(slow_osc_run),
      .fast_osc_run(fast_osc_run),
      .fast_osc_stable(fast_osc_stable),
      .cpu_clock_select_out(cpu_clock_select_out),
      .cpu_clk_en(cpu_clk_en),
      .timer_tick(timer_tick)
   );

   // 100 ns clock
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // one-cycle strobe on the io port, sampled 1 ns after the taking edge
   task automatic req(input logic [15:0] a, input logic [3:0] d,
      input logic w, input logic r);
      @(posedge sys_clk);
      io_req <= '{a, d, w, r};
      @(posedge sys_clk);
      io_req <= '{a, d, 1'b0, 1'b0};
      #1;
   endtask

   task automatic pulse_sleep(input logic s);
      @(posedge sys_clk);
      if (s) sleep_instruction <= 1'b1;
      else wake_event <= 1'b1;
      @(posedge sys_clk);
      sleep_instruction <= 1'b0;
      wake_event <= 1'b0;
      #1;
   endtask

   task automatic t_reset();
      `CHK("select", 1'b0, cpu_clock_select_out)
      `CHK("fast_run", 1'b0, fast_osc_run)
      `CHK("slow_run", 1'b1, slow_osc_run)
      req(OSC_CTRL_ADDR, 4'h0, 1'b0, 1'b1);
      `CHK("rdata", 4'h0, io_rdata)
      $display("test reset done");
   endtask

   // tick gap must fit a 32.768 kHz rate from the 10 MHz clock
   task automatic t_tick();
      int n;
      int k;
      for (k = 0; k < 2; k++)
      begin
         n = 0;
         do
         begin
            @(posedge sys_clk);
            #1;
            n++;
         end while (timer_tick !== 1'b1 && n < 400);
      end
      `CHK("tick_gap", 1'b1, (n == TICK_GAP_MIN || n == TICK_GAP_MAX))
      $display("test tick done");
   endtask

   task automatic t_fast();
      int n;
      int bad;
      req(OSC_CTRL_ADDR, 4'h4, 1'b1, 1'b0);
      `CHK("fast_run", 1'b1, fast_osc_run)
      `CHK("stable_early", 1'b0, fast_osc_stable)
      n = 0;
      while (fast_osc_stable !== 1'b1 && n < SETTLE + 4)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      `CHK("stable", 1'b1, fast_osc_stable)
      req(OSC_CTRL_ADDR, 4'hC, 1'b1, 1'b0);
      `CHK("select", 1'b1, cpu_clock_select_out)
      req(OSC_CTRL_ADDR, 4'h0, 1'b0, 1'b1);
      `CHK("rdata", 4'hC, io_rdata)
      bad = 0;
      repeat (4)
      begin
         @(posedge sys_clk);
         #1;
         if (cpu_clk_en !== 1'b1) bad++;
      end
      `CHK("fast_clk_en", 0, bad)
      t_tick();
      req(OSC_CTRL_ADDR, 4'h4, 1'b1, 1'b0);
      `CHK("select", 1'b0, cpu_clock_select_out)
      req(OSC_CTRL_ADDR, 4'h0, 1'b1, 1'b0);
      `CHK("fast_run", 1'b0, fast_osc_run)
      bad = 0;
      repeat (320)
      begin
         @(posedge sys_clk);
         #1;
         if (cpu_clk_en !== timer_tick) bad++;
      end
      `CHK("slow_clk_en", 0, bad)
      $display("test fast done");
   endtask

   // enable bit survives sleep, so fast restarts on wake
   task automatic t_sleep();
      req(OSC_CTRL_ADDR, 4'h4, 1'b1, 1'b0);
      pulse_sleep(1'b1);
      `CHK("slow_run", 1'b0, slow_osc_run)
      `CHK("fast_run", 1'b0, fast_osc_run)
      `CHK("clk_en", 1'b0, cpu_clk_en)
      pulse_sleep(1'b0);
      `CHK("slow_run", 1'b1, slow_osc_run)
      `CHK("fast_run", 1'b1, fast_osc_run)
      `CHK("stable_wake", 1'b0, fast_osc_stable)
      $display("test sleep done");
   endtask

   task automatic t_unmapped();
      req(16'hFF01, 4'hC, 1'b1, 1'b0);
      `CHK("fast_run", 1'b1, fast_osc_run)
      `CHK("select", 1'b0, cpu_clock_select_out)
      req(16'hFF01, 4'h0, 1'b0, 1'b1);
      `CHK("rdata", 4'h0, io_rdata)
      $display("test unmapped done");
   endtask

   // write then read on adjacent edges: the read sees the new word
   task automatic t_back_to_back();
      @(posedge sys_clk);
      io_req <= '{OSC_CTRL_ADDR, 4'h0, 1'b1, 1'b0};
      @(posedge sys_clk);
      io_req <= '{OSC_CTRL_ADDR, 4'h0, 1'b0, 1'b1};
      @(posedge sys_clk);
      io_req <= '{OSC_CTRL_ADDR, 4'h0, 1'b0, 1'b0};
      #1;
      `CHK("rdata_b2b", 4'h0, io_rdata)
      `CHK("fast_run", 1'b0, fast_osc_run)
      $display("test back to back done");
   endtask

   task automatic results();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // main sequence
   initial
   begin
      num_errors = 0;
      n_compared = 0;
      sys_rst = 1'b1;
      io_req = '{16'h0000, 4'h0, 1'b0, 1'b0};
      sleep_instruction = 1'b0;
      wake_event = 1'b0;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      t_reset();
      t_tick();
      t_fast();
      t_sleep();
      t_unmapped();
      t_back_to_back();
      results();
   end

   // watchdog, well past the roughly 1600 cycles the tests need
   initial
   begin
      #2000000;
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
